// *** inc/rcid_pkg.sv ***
// Constants, types and register map of the real-time control input decoder
// Contract
// - Line PLL increment field is ignored
// - Enabled: subcarrier from received increment, except internal one when colour decode is on and colour bit is 0
// - Phase-alternation bit marks inverted R-Y line
// - Phase reset per line when reset bit set
// - Received field-rate bit replaces register copy
// - Received odd/even bit replaces internal parity
// - Colour bit 0: internal subcarrier increment
// - Colour bit 1: received subcarrier increment
// - Colour decode off: always received increment
// - Parity status reads 1 even, 0 odd
package rcid_pkg;

  // ==========================================================
  // Serial frame layout
  localparam int unsigned LINE_INC_W = 14;   // Line PLL increment width
  localparam int unsigned SUBC_INC_W = 22;   // Subcarrier increment width
  localparam int unsigned FRAME_BITS = 41;   // Bits after the start bit
  localparam logic [5:0] CNT_LAST = 6'h28;   // Index of last frame bit
  localparam logic [5:0] CNT_ZERO = 6'h00;   // Counter start
  localparam logic [5:0] CNT_ONE = 6'h01;    // Counter step

  // Frame as received, first bit in the MSB
  typedef struct packed {
    logic [LINE_INC_W-1:0] line_inc;  // Line PLL increment
    logic [SUBC_INC_W-1:0] subc_inc;  // Subcarrier PLL increment
    logic pal_bit;                    // Inverted R-Y line marker
    logic reset_bit;                  // Subcarrier phase reset
    logic field_rate;                 // Field-rate select
    logic even_bit;                   // 1 = even field
    logic colour_bit;                 // 1 = colour detected
  } rcid_frame_t;

  // Receiver states, Gray along idle, shift, latch
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SHIFT = 2'b01,
    RX_LATCH = 2'b11
  } rcid_state_t;

  // Control register
  typedef struct packed {
    logic colour_detect_decode_enable;  // Bit 7
    logic parity_decode_enable;         // Bit 6
    logic field_rate_select;            // Bit 5, register copy
    logic field_rate_decode_enable;     // Bit 4
    logic [1:0] phase_reset_select;     // Bits 3:2
    logic phase_reset_decode_enable;    // Bit 1
    logic realtime_ctrl_enable;         // Bit 0
  } rcid_ctrl_t;

  // Registered outputs toward the encoder core
  typedef struct packed {
    logic [SUBC_INC_W-1:0] subc_inc;  // Increment in use
    logic phase_reset;                // One-cycle phase reset
    logic field_rate;                 // Field rate in use
    logic even_field;                 // 1 = even field
    logic rminusy_invert;             // Invert R-Y this line
  } rcid_out_t;

  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;    // Control
  localparam logic [3:0] ADDR_INC = 4'h4;     // Internal increment
  localparam logic [3:0] ADDR_STATUS = 4'h8;  // Status
  localparam logic [3:0] ADDR_RXINC = 4'hc;   // Increment in use
  localparam logic [7:0] CTRL_RESET = 8'h00;  // Control reset value
  localparam logic [SUBC_INC_W-1:0] INC_RESET = 22'h000000;
  localparam logic [1:0] PHASE_RESET_SELECT_LINE = 2'h0;   // Per-line reset mode
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : rcid_pkg

// *** rtl/rcid_decoder.sv ***
// Real-time control input decoder with AHB-Lite register slave
`timescale 1ns/1ps
module rcid_decoder
  import rcid_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic realtime_ctrl_input,
  input wire logic line_start,
  input wire logic int_even_field,
  input wire logic int_phase_reset,
  output logic [SUBC_INC_W-1:0] subcarrier_increment,
  output logic subcarrier_phase_reset,
  output logic field_rate,
  output logic even_field,
  output logic rminusy_invert
);

  // ==========================================================
  // Serial receiver
  rcid_state_t state_ff, nxt_state;      // Receiver state
  logic [5:0] cnt_ff, nxt_cnt;           // Bit counter
  logic [FRAME_BITS-1:0] sr_ff, nxt_sr;  // Shift register
  rcid_frame_t rx_ff, nxt_rx;            // Last complete frame

  // Next receiver values
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sr = sr_ff;
    nxt_rx = rx_ff;
    unique case (state_ff)
      RX_IDLE: begin
        // Start bit opens a frame
        if (realtime_ctrl_input) begin
          nxt_state = RX_SHIFT;
          nxt_cnt = CNT_ZERO;
        end
      end
      RX_SHIFT: begin
        // First bit ends up in the MSB
        nxt_sr = {sr_ff[FRAME_BITS-2:0], realtime_ctrl_input};
        nxt_cnt = cnt_ff + CNT_ONE;
        if (cnt_ff == CNT_LAST) begin
          nxt_state = RX_LATCH;
        end
      end
      RX_LATCH: begin
        // Whole frame taken at once
        nxt_rx = rcid_frame_t'(sr_ff);
        nxt_state = RX_IDLE;
      end
      default: begin
        nxt_state = RX_IDLE;
      end
    endcase
  end

  // Receiver registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= RX_IDLE;
      cnt_ff <= CNT_ZERO;
      sr_ff <= '0;
      rx_ff <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sr_ff <= nxt_sr;
      rx_ff <= nxt_rx;
    end
  end

  // ==========================================================
  // AHB-Lite slave
  rcid_ctrl_t ctrl_ff, nxt_ctrl;                // Control register
  logic [SUBC_INC_W-1:0] inc_ff, nxt_inc;       // Internal increment
  logic wr_ff, nxt_wr;                          // Write data phase
  logic [3:0] waddr_ff, nxt_waddr;              // Write address
  logic [31:0] rdata_ff, nxt_rdata;             // Read data
  logic take;                                   // Address phase taken
  rcid_out_t out_ff, nxt_out;                   // Core outputs

  // Bus stalls while the clock enable is low
  assign hreadyout = clk_en;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_ff;
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Next bus and register values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_inc = inc_ff;
    nxt_wr = take && hwrite;
    nxt_waddr = haddr[3:0];
    nxt_rdata = 32'h00000000;
    // Write data phase
    if (wr_ff) begin
      unique case (waddr_ff)
        ADDR_CTRL: nxt_ctrl = rcid_ctrl_t'(hwdata[7:0]);
        ADDR_INC: nxt_inc = hwdata[SUBC_INC_W-1:0];
        default: ;
      endcase
    end
    // Read data prepared in the address phase
    if (take && !hwrite) begin
      unique case (haddr[3:0])
        ADDR_CTRL: nxt_rdata = {24'h000000, ctrl_ff};
        ADDR_INC: nxt_rdata = {10'h000, inc_ff};
        ADDR_STATUS: begin
          // Parity status: 1 even, 0 odd
          nxt_rdata = {28'h0000000, rx_ff.colour_bit,
                       out_ff.rminusy_invert, out_ff.field_rate,
                       out_ff.even_field};
        end
        ADDR_RXINC: nxt_rdata = {10'h000, out_ff.subc_inc};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= rcid_ctrl_t'(CTRL_RESET);
      inc_ff <= INC_RESET;
      wr_ff <= 1'b0;
      waddr_ff <= ADDR_CTRL;
      rdata_ff <= 32'h00000000;
    end else if (clk_en) begin
      ctrl_ff <= nxt_ctrl;
      inc_ff <= nxt_inc;
      wr_ff <= nxt_wr;
      waddr_ff <= nxt_waddr;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Source selection
  logic rt_on;      // Real-time control enabled
  logic use_rx_fsc; // Take received increment

  // Disabled control leaves every internal source in charge
  assign rt_on = ctrl_ff.realtime_ctrl_enable;
  // Line PLL increment is never read
  assign use_rx_fsc = rt_on &&
    (!ctrl_ff.colour_detect_decode_enable ||
     rx_ff.colour_bit);

  // Next core outputs
  always_comb begin
    nxt_out = out_ff;
    nxt_out.subc_inc = use_rx_fsc ? rx_ff.subc_inc : inc_ff;
    // Per-line phase reset from the received bit
    if (rt_on && ctrl_ff.phase_reset_decode_enable) begin
      nxt_out.phase_reset = line_start && rx_ff.reset_bit &&
        (ctrl_ff.phase_reset_select == PHASE_RESET_SELECT_LINE);
    end else begin
      nxt_out.phase_reset = int_phase_reset;
    end
    // Field rate from stream or register copy
    if (rt_on && ctrl_ff.field_rate_decode_enable) begin
      nxt_out.field_rate = rx_ff.field_rate;
    end else begin
      nxt_out.field_rate = ctrl_ff.field_rate_select;
    end
    // Field parity from stream or internal generator
    if (rt_on && ctrl_ff.parity_decode_enable) begin
      nxt_out.even_field = rx_ff.even_bit;
    end else begin
      nxt_out.even_field = int_even_field;
    end
    // Inverted R-Y line marked by the source
    nxt_out.rminusy_invert = rt_on && rx_ff.pal_bit;
  end

  // Output registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff <= '0;
    end else if (clk_en) begin
      out_ff <= nxt_out;
    end
  end

  assign subcarrier_increment = out_ff.subc_inc;
  assign subcarrier_phase_reset = out_ff.phase_reset;
  assign field_rate = out_ff.field_rate;
  assign even_field = out_ff.even_field;
  assign rminusy_invert = out_ff.rminusy_invert;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Start bit seen in idle
  sequence s_start;
    clk_en && state_ff == RX_IDLE && realtime_ctrl_input;
  endsequence

  // Internal increment used when no colour is detected
  a_colour_off_inc: assert property (
    (clk_en && rt_on && ctrl_ff.colour_detect_decode_enable &&
     !rx_ff.colour_bit) |=> subcarrier_increment == $past(inc_ff))
    else $error("internal increment not used");

  // Received increment used when colour is detected
  a_colour_on_inc: assert property (
    (clk_en && rt_on && rx_ff.colour_bit) |=>
      subcarrier_increment == $past(rx_ff.subc_inc))
    else $error("received increment not used");

  // Colour bit ignored without its decode enable
  a_colour_dis_inc: assert property (
    (clk_en && rt_on && !ctrl_ff.colour_detect_decode_enable) |=>
      subcarrier_increment == $past(rx_ff.subc_inc))
    else $error("colour bit not ignored");

  // Disabled control leaves internal sources
  a_disabled_int: assert property (
    (clk_en && !rt_on) |=> (subcarrier_increment == $past(inc_ff) &&
      even_field == $past(int_even_field) && !rminusy_invert))
    else $error("stream used while disabled");

  // Phase reset pulse on a line with reset bit
  a_phase_reset: assert property (
    (clk_en && rt_on && ctrl_ff.phase_reset_decode_enable &&
     ctrl_ff.phase_reset_select == PHASE_RESET_SELECT_LINE && rx_ff.reset_bit &&
     line_start) |=> subcarrier_phase_reset)
    else $error("phase reset missed");

  // Received field rate overrides register copy
  a_field_rate: assert property (
    (clk_en && rt_on && ctrl_ff.field_rate_decode_enable) |=>
      field_rate == $past(rx_ff.field_rate))
    else $error("field rate not taken from stream");

  // Received parity overrides internal parity
  a_parity_rx: assert property (
    (clk_en && rt_on && ctrl_ff.parity_decode_enable) |=>
      even_field == $past(rx_ff.even_bit))
    else $error("parity not taken from stream");

  // Frame still shifting eight enabled cycles after the start bit
  a_frame_len: assert property (
    s_start ##1 clk_en [*8] |-> state_ff == RX_SHIFT)
    else $error("frame ended early");

  // Last data bit seen while shifting
  sequence s_last_bit;
    clk_en && state_ff == RX_SHIFT && cnt_ff == CNT_LAST;
  endsequence

  // Latch follows the last data bit
  a_frame_end: assert property (
    s_last_bit |=> state_ff == RX_LATCH)
    else $error("frame not latched after last bit");

  // Latched frame equals the shifted bits
  a_latch_frame: assert property (
    (clk_en && state_ff == RX_LATCH) |=>
      rx_ff == rcid_frame_t'($past(sr_ff)))
    else $error("latched frame differs from shifted bits");

  // Register copy of field rate without its decode enable
  a_field_copy: assert property (
    (clk_en && !(rt_on && ctrl_ff.field_rate_decode_enable)) |=>
      field_rate == $past(ctrl_ff.field_rate_select))
    else $error("field rate register copy not used");

  // Internal parity without its decode enable
  a_parity_int: assert property (
    (clk_en && !(rt_on && ctrl_ff.parity_decode_enable)) |=>
      even_field == $past(int_even_field))
    else $error("internal parity not used");

  // Internal phase reset passes without its decode enable
  a_phase_pass: assert property (
    (clk_en && !(rt_on && ctrl_ff.phase_reset_decode_enable)) |=>
      subcarrier_phase_reset == $past(int_phase_reset))
    else $error("internal phase reset not passed");

  // Other select codes never reset the phase
  a_phase_select: assert property (
    (clk_en && rt_on && ctrl_ff.phase_reset_decode_enable &&
     ctrl_ff.phase_reset_select != PHASE_RESET_SELECT_LINE) |=>
      !subcarrier_phase_reset)
    else $error("phase reset outside per-line mode");

  // R-Y inversion follows the received marker
  a_rminusy_mark: assert property (
    (clk_en && rt_on) |=> rminusy_invert == $past(rx_ff.pal_bit))
    else $error("R-Y inversion marker not followed");

  // Status bit 0 tracks even field
  a_status_parity: assert property (
    (clk_en && take && !hwrite && haddr[3:0] == ADDR_STATUS) |=>
      hrdata[0] == $past(even_field))
    else $error("parity status wrong");

endmodule : rcid_decoder

// *** verif/rcid_src_model.sv ***
// Upstream decoder model that sends serial control frames
`timescale 1ns/1ps
module rcid_src_model
  import rcid_pkg::*;
(
  input wire logic hclk,
  output logic realtime_ctrl_input
);
  // ==========================================================
  // Line sits low between frames, so no false start bit
  initial realtime_ctrl_input = 1'b0;
  // Start bit, then the frame MSB first, one bit per edge
  task automatic send(input rcid_frame_t f);
    int i;
    @(posedge hclk);
    realtime_ctrl_input <= 1'b1;
    for (i = FRAME_BITS - 1; i >= 0; i--) begin
      @(posedge hclk);
      realtime_ctrl_input <= f[i];
    end
    @(posedge hclk);
    realtime_ctrl_input <= 1'b0;
  endtask
endmodule // rcid_src_model

// *** verif/rcid_decoder_tb.sv ***
// Self-checking bench for the real-time control input decoder
`timescale 1ns/1ps
module rcid_decoder_tb
  import rcid_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic clk_en = 1'b1;
  logic line_start = 1'b0;
  logic int_even_field = 1'b0;
  logic int_phase_reset = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, realtime_ctrl_input, subcarrier_phase_reset;
  logic field_rate, even_field, rminusy_invert;
  logic [31:0] hrdata;
  logic [SUBC_INC_W-1:0] subcarrier_increment;
  int error_cnt = 0;  // Mismatches seen
  int n_checks = 0;   // Comparisons made
  int cyc = 0;        // Cycles since start

  // Device and upstream source; single slave, so hready loops back
  rcid_decoder i_dut (
    .hclk, .hresetn, .clk_en, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .realtime_ctrl_input, .line_start,
    .int_even_field, .int_phase_reset, .subcarrier_increment,
    .subcarrier_phase_reset, .field_rate, .even_field, .rminusy_invert
  );
  rcid_src_model i_src (.hclk, .realtime_ctrl_input);

  // 50 MHz clock
  always #10 hclk = ~hclk;

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      conclude();
    end
  end

  // ==========================================================
  // Comparison and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // AHB-Lite single word transfer, waits on hready each phase
  task automatic ahb(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge hclk);
    haddr <= {28'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    chk(32'(hresp), 32'(HRESP_OKAY));
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask

  // Send one frame and let the fields settle at the outputs
  task automatic frame(input rcid_frame_t f);
    i_src.send(f);
    repeat (4) @(posedge hclk);
  endtask
  // Increment in use and {field rate, even field, R-Y invert}
  task automatic outs(input logic [31:0] inc, input logic [2:0] fl);
    chk(32'(subcarrier_increment), inc);
    chk(32'({field_rate, even_field, rminusy_invert}), 32'(fl));
  endtask
  // One line start; count phase reset pulses that follow
  task automatic line(input logic ip, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge hclk);
    line_start <= 1'b1;
    int_phase_reset <= ip;
    @(posedge hclk);
    line_start <= 1'b0;
    int_phase_reset <= 1'b0;
    // Pulse registered at this edge stands until the next one
    repeat (4) begin
      #1 if (subcarrier_phase_reset === 1'b1) n++;
      @(posedge hclk);
    end
    chk(n, exp);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    rd(ADDR_INC, 32'(INC_RESET));
    rd(ADDR_RXINC, 32'h0);
    $display("test reset done");
    // Control off: stream must not reach the outputs
    wr(ADDR_CTRL, 32'h70);
    wr(ADDR_INC, 32'h12345);
    int_even_field <= 1'b1;
    frame('{14'h0, 22'h3abcde, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1});
    outs(32'h12345, 3'b110);
    line(1'b0, 32'h0);
    $display("test control off done");
    // Field rate, parity and increment taken from the stream
    wr(ADDR_CTRL, 32'h51);
    frame('{14'h1555, 22'h2aaaaa, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
    outs(32'h2aaaaa, 3'b101);
    rd(ADDR_STATUS, 32'h6);
    frame('{14'h2aaa, 22'h2aaaaa, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    outs(32'h2aaaaa, 3'b010);
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_RXINC, 32'h2aaaaa);
    $display("test stream fields done");
    // Colour detect decode picks internal or received increment
    wr(ADDR_CTRL, 32'h81);
    frame('{14'h0, 22'h155555, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    outs(32'h12345, 3'b010);
    frame('{14'h0, 22'h155555, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
    outs(32'h155555, 3'b010);
    rd(ADDR_STATUS, 32'h9);
    $display("test colour detect done");
    // Phase reset per line, only in select mode 00
    wr(ADDR_CTRL, 32'h03);
    frame('{14'h0, 22'h155555, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1});
    line(1'b0, 32'h1);
    wr(ADDR_CTRL, 32'h07);
    line(1'b0, 32'h0);
    wr(ADDR_CTRL, 32'h01);
    line(1'b1, 32'h1);
    // Clock enable low freezes outputs and stalls the bus
    clk_en <= 1'b0;
    line(1'b1, 32'h0);
    chk(32'(hreadyout), 32'h0);
    clk_en <= 1'b1;
    $display("test phase reset done");
    conclude();
  end
endmodule // rcid_decoder_tb
